// file: logic/tcc_pkg.sv
// constants, types and register map of the 8-bit capture timer
//==========================================================
// What this block does
// [R1] Three modes are offered: interval timer, event counter and input capture; the fourth mode code, idle, holds the count.
// [R2] Two 8-bit registers, compare/capture A and capture B, are not touched by reset.
// [R3] Timer mode counts the internal clock; a match with A raises the irq and restarts.
// [R4] The internal clock is one of five prescaler taps picked by clock select, tap select and slow mode.
// [R5] Writing 1 to the soft capture bit in timer or event mode copies the count to B.
// [R6] Event mode counts pin edges, rising or falling as the edge select bit says.
// [R7] Event mode raises the irq and clears the counter when the count matches A.
// [R8] The source keeps event pulses no faster than the high or low clock over sixteen.
// [R9] The source holds each pin level for at least two machine cycles.
// [R10] Capture mode free-runs; the active edge loads A, clears the counter, raises the irq.
// [R11] Capture mode loads B on the opposite edge and keeps counting.
// [R12] Capture mode overflow before the active edge writes ff to A and raises the irq.
// [R13] After a capture to A or an overflow, detection waits until software reads A.
// [R14] Software should read B before A when serving a capture irq.
// [R15] With start off the counter is held at zero; start counts up from zero.
package tcc_pkg;

    //==========================================================
    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CMP_A   = 8'h04;
    localparam logic [7:0] ADDR_CAP_B   = 8'h08;
    localparam logic [7:0] ADDR_EXT_CTL = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_CLEAR   = 8'h14;
    localparam logic [7:0] ADDR_ENABLE  = 8'h18;

    localparam int         EDGE_SEL_BIT = 3;
    localparam int         ST_MATCH     = 0;
    localparam int         ST_CAP_A     = 1;
    localparam int         ST_OVF       = 2;
    localparam int         ST_CAP_B     = 3;
    localparam int         ST_W         = 4;
    localparam logic [7:0] CNT_FULL     = 8'hff;
    localparam logic [7:0] CTRL_RST     = 8'h00;

    //==========================================================
    // prescaler tap exponents
    localparam int FC_EXP0 = 12;
    localparam int FC_EXP1 = 10;
    localparam int FC_EXP2 = 7;
    localparam int FS_EXP0 = 4;
    localparam int FS_EXP1 = 2;

    //==========================================================
    // types
    typedef enum logic [1:0] {
        TCC_TIMER,
        TCC_EVENT,
        TCC_CAPTURE,
        TCC_IDLE
    } tcc_mode_t;

    typedef struct packed {
        logic       slow;
        logic       soft_capture_request;
        logic       prescaler_tap_select;
        logic       start;
        logic [1:0] clk_sel;
        logic [1:0] mode;
    } tcc_ctl_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } tcc_edge_t;

endpackage : tcc_pkg

// file: logic/tcc_edge.sv
// pin synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module tcc_edge (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pin,
    output tcc_pkg::tcc_edge_t edge_pulse
);
    logic s1;
    logic s2;
    logic s3;

    //==========================================================
    // two stages, then a third for edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    assign edge_pulse.rise = s2 & ~s3;
    assign edge_pulse.fall = ~s2 & s3;

endmodule : tcc_edge
`default_nettype wire

// file: logic/tcc_prescaler.sv
// prescaler: high and low frequency tap enables
`timescale 1ns/1ps
`default_nettype none
module tcc_prescaler #(
    parameter int FS_DIV = 8
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       prescaler_tap_select,
    input  wire logic       slow,
    input  wire logic [1:0] clk_sel,
    output logic            tick
);
    localparam int FSW = (FS_DIV > 2) ? $clog2(FS_DIV) : 1;

    if (FS_DIV < 2) begin : g_bad_div
        $error("FS_DIV must be at least 2");
    end

    logic [tcc_pkg::FC_EXP0-1:0] div;
    logic [FSW-1:0]              fs_cnt;
    logic                        fs_en;
    logic [tcc_pkg::FS_EXP0-1:0] fsd;
    logic                        fc0;
    logic                        fc1;
    logic                        fc2;
    logic                        fs0;
    logic                        fs1;

    //==========================================================
    // high clock is pclk itself; low clock is an enable every FS_DIV
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_cnt <= '0;
        end else if (fs_en) begin
            fs_cnt <= '0;
        end else begin
            fs_cnt <= fs_cnt + 1'b1;
        end
    end

    assign fs_en = (fs_cnt == FSW'(FS_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsd <= '0;
        end else if (fs_en) begin
            fsd <= fsd + 1'b1;
        end
    end

    assign fc0 = &div[tcc_pkg::FC_EXP0-1:0];
    assign fc1 = &div[tcc_pkg::FC_EXP1-1:0];
    assign fc2 = &div[tcc_pkg::FC_EXP2-1:0];
    assign fs0 = fs_en & (&fsd[tcc_pkg::FS_EXP0-1:0]);
    assign fs1 = fs_en & (&fsd[tcc_pkg::FS_EXP1-1:0]);

    //==========================================================
    // tap mux; slow mode has only the low clock over sixteen
    always_comb begin
        tick = 1'b0;
        if (slow) begin
            tick = (clk_sel == 2'h0) & fs0; // R4
        end else begin
            case (clk_sel)
                2'h0:    tick = prescaler_tap_select ? fs0 : fc0; // R4
                2'h1:    tick = prescaler_tap_select ? fs1 : fc1; // R4
                2'h2:    tick = fc2; // R4
                default: tick = 1'b0;
            endcase
        end
    end

endmodule : tcc_prescaler
`default_nettype wire

// file: logic/tcc_timer.sv
// 8-bit timer/counter with event count and input capture, APB slave
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer #(
    parameter int FS_DIV = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_input_pin,
    output logic             timer_irq
);
    tcc_pkg::tcc_ctl_t       timer_control_reg;
    tcc_pkg::tcc_mode_t      mode;
    tcc_pkg::tcc_edge_t      pin_edge;
    logic [7:0]              ext_int_control_reg;
    logic [7:0]              compare_capture_a;
    logic [7:0]              capture_b;
    logic [7:0]              cnt;
    logic [7:0]              cnt_inc;
    logic [tcc_pkg::ST_W-1:0] status;
    logic [tcc_pkg::ST_W-1:0] irq_enable;
    logic [tcc_pkg::ST_W-1:0] status_set;
    logic [tcc_pkg::ST_W-1:0] status_clr;
    logic                    armed;
    logic                    soft_pend;
    logic                    int_tick;
    logic                    ev_tick;
    logic                    active_edge;
    logic                    other_edge;
    logic                    running;
    logic                    count_mode;
    logic                    match;
    logic                    cap_a_ev;
    logic                    cap_b_ev;
    logic                    ovf_ev;
    logic                    wr;
    logic                    rd;
    logic                    hit;
    logic                    rd_a;
    logic [31:0]             rdata;

    if (FS_DIV < 2) begin : g_bad_div
        $error("FS_DIV must be at least 2");
    end

    //==========================================================
    // submodules
    tcc_prescaler #(
        .FS_DIV (FS_DIV)
    ) u_presc (
        .pclk                 (pclk),
        .presetn              (presetn),
        .prescaler_tap_select (timer_control_reg.prescaler_tap_select),
        .slow                 (timer_control_reg.slow),
        .clk_sel              (timer_control_reg.clk_sel),
        .tick                 (int_tick)
    );

    tcc_edge u_edge (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (timer_input_pin),
        .edge_pulse (pin_edge)
    );

    //==========================================================
    // mode decode and events
    assign mode    = tcc_pkg::tcc_mode_t'(timer_control_reg.mode); // R1
    assign running = timer_control_reg.start;
    assign cnt_inc = cnt + 8'h01;

    // edge select 0: rising counts / is active
    assign active_edge = ext_int_control_reg[tcc_pkg::EDGE_SEL_BIT]
                       ? pin_edge.fall : pin_edge.rise; // R6
    assign other_edge  = ext_int_control_reg[tcc_pkg::EDGE_SEL_BIT]
                       ? pin_edge.rise : pin_edge.fall;

    always_comb begin
        count_mode = 1'b0;
        ev_tick    = 1'b0;
        case (mode)
            tcc_pkg::TCC_TIMER: begin
                count_mode = 1'b1;
                ev_tick    = int_tick; // R3
            end
            tcc_pkg::TCC_EVENT: begin
                count_mode = 1'b1;
                ev_tick    = active_edge; // R6
            end
            tcc_pkg::TCC_CAPTURE: begin
                count_mode = 1'b0;
                ev_tick    = int_tick; // R10
            end
            default: begin
                count_mode = 1'b0;
                ev_tick    = 1'b0;
            end
        endcase
    end

    // match is on the incremented value, so A sets the period in ticks
    assign match    = running & count_mode & ev_tick
                    & (cnt_inc == compare_capture_a); // R3 R7
    assign cap_a_ev = running & (mode == tcc_pkg::TCC_CAPTURE)
                    & armed & active_edge; // R10 R13
    assign cap_b_ev = running & (mode == tcc_pkg::TCC_CAPTURE)
                    & armed & other_edge; // R11 R13
    // an active edge in the same cycle takes priority over the overflow
    assign ovf_ev   = running & (mode == tcc_pkg::TCC_CAPTURE) & armed
                    & ~active_edge & int_tick
                    & (cnt == tcc_pkg::CNT_FULL); // R12

    //==========================================================
    // up-counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
        end else if (!running) begin
            cnt <= 8'h00; // R15
        end else if (match || cap_a_ev) begin
            cnt <= 8'h00; // R3 R7 R10
        end else if (ev_tick) begin
            cnt <= cnt_inc; // R11 R13
        end
    end

    //==========================================================
    // APB decode; zero wait states
    assign wr     = psel & penable & pwrite;
    assign rd     = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign rd_a   = rd & (paddr == tcc_pkg::ADDR_CMP_A);

    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        if (paddr == tcc_pkg::ADDR_CTRL) begin
            rdata[7:0] = {timer_control_reg[7], 1'b0, timer_control_reg[5:0]};
        end else if (paddr == tcc_pkg::ADDR_CMP_A) begin
            rdata[7:0] = compare_capture_a;
        end else if (paddr == tcc_pkg::ADDR_CAP_B) begin
            rdata[7:0] = capture_b;
        end else if (paddr == tcc_pkg::ADDR_EXT_CTL) begin
            rdata[7:0] = ext_int_control_reg;
        end else if (paddr == tcc_pkg::ADDR_STATUS) begin
            rdata[tcc_pkg::ST_W-1:0] = status;
        end else if (paddr == tcc_pkg::ADDR_CLEAR) begin
            rdata = 32'h0000_0000;
        end else if (paddr == tcc_pkg::ADDR_ENABLE) begin
            rdata[tcc_pkg::ST_W-1:0] = irq_enable;
        end else begin
            hit = 1'b0;
        end
    end

    assign prdata  = rd ? rdata : 32'h0000_0000;
    assign pslverr = psel & penable & ~hit;

    //==========================================================
    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_reg <= tcc_pkg::CTRL_RST;
        end else if (wr && paddr == tcc_pkg::ADDR_CTRL) begin
            timer_control_reg <= pwdata[7:0];
            timer_control_reg.soft_capture_request <= 1'b0; // R5
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_int_control_reg <= 8'h00;
        end else if (wr && paddr == tcc_pkg::ADDR_EXT_CTL) begin
            ext_int_control_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= '0;
        end else if (wr && paddr == tcc_pkg::ADDR_ENABLE) begin
            irq_enable <= pwdata[tcc_pkg::ST_W-1:0];
        end
    end

    // soft capture: one-cycle request, reads back as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_pend <= 1'b0;
        end else begin
            soft_pend <= wr && paddr == tcc_pkg::ADDR_CTRL
                      && pwdata[6] && mode != tcc_pkg::TCC_CAPTURE; // R5
        end
    end

    //==========================================================
    // timer registers; no reset on purpose
    always_ff @(posedge pclk) begin
        if (cap_a_ev) begin
            compare_capture_a <= cnt; // R10
        end else if (ovf_ev) begin
            compare_capture_a <= tcc_pkg::CNT_FULL; // R12
        end else if (wr && paddr == tcc_pkg::ADDR_CMP_A) begin
            compare_capture_a <= pwdata[7:0]; // R2
        end
    end

    always_ff @(posedge pclk) begin
        if (cap_b_ev) begin
            capture_b <= cnt; // R11
        end else if (soft_pend) begin
            capture_b <= cnt; // R5
        end
    end

    //==========================================================
    // capture arm; a read of A re-enables detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b1;
        end else if (cap_a_ev || ovf_ev) begin
            armed <= 1'b0; // R13
        end else if (rd_a) begin
            armed <= 1'b1; // R13
        end
    end

    //==========================================================
    // interrupt status; set wins over clear
    assign status_set = {cap_b_ev, ovf_ev, cap_a_ev, match};
    assign status_clr = (wr && paddr == tcc_pkg::ADDR_CLEAR)
                      ? pwdata[tcc_pkg::ST_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else begin
            status <= (status & ~status_clr) | status_set;
        end
    end

    // the capture-B bit is status only; enable it to wake on B too
    assign timer_irq = |(status & irq_enable); // R3 R7 R10 R12

    //==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stop_holds_zero: assert property (!running ##1 !running |-> cnt == 8'h00) // R15
        else $error("counter not zero while stopped");

    a_timer_match_clr: assert property (
        mode == tcc_pkg::TCC_TIMER && match |=> cnt == 8'h00 && status[tcc_pkg::ST_MATCH]) // R3
        else $error("timer match did not clear and flag");

    a_event_counts_up: assert property (
        mode == tcc_pkg::TCC_EVENT && running && active_edge && !match
        |=> cnt == 8'($past(cnt) + 8'h01)) // R6
        else $error("event edge not counted");

    a_event_match_irq: assert property (
        mode == tcc_pkg::TCC_EVENT && match && irq_enable[tcc_pkg::ST_MATCH]
        |=> timer_irq && cnt == 8'h00) // R7
        else $error("event match gave no irq");

    a_soft_cap_b: assert property (soft_pend && !cap_b_ev |=> capture_b == $past(cnt)) // R5
        else $error("soft capture missed");

    a_cap_a_load: assert property (
        cap_a_ev |=> compare_capture_a == $past(cnt) && cnt == 8'h00 && !armed) // R10
        else $error("active edge capture wrong");

    a_cap_b_load: assert property (
        cap_b_ev |=> capture_b == $past(cnt) && status[tcc_pkg::ST_CAP_B]) // R11
        else $error("opposite edge capture wrong");

    a_ovf_marks_ff: assert property (
        ovf_ev |=> compare_capture_a == tcc_pkg::CNT_FULL && status[tcc_pkg::ST_OVF]) // R12
        else $error("overflow not marked");

    a_hold_until_read: assert property (
        !armed && !rd_a |=> !armed) // R13
        else $error("detection resumed without read");

    a_read_rearms: assert property (
        rd_a && !cap_a_ev && !ovf_ev |=> armed) // R13
        else $error("read of A did not rearm");

    a_tick_slow_mode: assert property (
        timer_control_reg.slow && timer_control_reg.clk_sel != 2'h0 |-> !int_tick) // R4
        else $error("fast tap active in slow mode");

    a_timer_tick_inc: assert property ( // R3
        mode == tcc_pkg::TCC_TIMER && running && ev_tick && !match
        |=> cnt == 8'($past(cnt) + 8'h01))
        else $error("timer tick not counted");

    a_cap_free_run: assert property ( // R10
        mode == tcc_pkg::TCC_CAPTURE && running && ev_tick && !cap_a_ev
        |=> cnt == 8'($past(cnt) + 8'h01))
        else $error("capture counter not free running");

    a_cap_b_keeps: assert property ( // R11
        cap_b_ev && !int_tick |=> cnt == $past(cnt))
        else $error("capture B disturbed the counter");

    a_idle_holds: assert property ( // R1
        mode == tcc_pkg::TCC_IDLE && running |=> cnt == $past(cnt))
        else $error("counter moved in idle mode");

    a_cmp_a_held: assert property ( // R13
        !armed && !(wr && paddr == tcc_pkg::ADDR_CMP_A)
        |=> compare_capture_a == $past(compare_capture_a))
        else $error("register A changed while halted");

    a_cap_b_held: assert property ( // R13
        !armed && !soft_pend |=> capture_b == $past(capture_b))
        else $error("register B changed while halted");

    a_clear_drops: assert property ( // R3
        status_clr[tcc_pkg::ST_MATCH] && !match |=> !status[tcc_pkg::ST_MATCH])
        else $error("match flag not cleared");

    a_flag_sticky: assert property ( // R12
        status[tcc_pkg::ST_OVF] && !status_clr[tcc_pkg::ST_OVF] |=> status[tcc_pkg::ST_OVF])
        else $error("overflow flag lost");

    a_ovf_wraps: assert property ( // R12
        ovf_ev |=> cnt == 8'h00)
        else $error("counter did not wrap on overflow");

    a_start_at_zero: assert property ( // R15
        $rose(running) |-> cnt == 8'h00)
        else $error("start did not begin at zero");

endmodule : tcc_timer
`default_nettype wire

// file: testbench/tcc_pulse_src.sv
// model of the external pulse source on the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tcc_pulse_src #(
    parameter int MIN_HALF = 8
) (
    input  wire logic pclk,
    output var logic  pin
);
    //==========================================================
    // pin drive, changed only just after a rising edge
    initial pin = 1'b0;

    // a half period is never cut below MIN_HALF, whatever the caller asks
    task automatic level(input logic v, input int half);
        pin <= v;
        repeat ((half < MIN_HALF) ? MIN_HALF : half) @(posedge pclk);
    endtask : level

    task automatic pulse(input int n);
        repeat (n) begin
            level(1'b1, MIN_HALF);
            level(1'b0, MIN_HALF);
        end
    endtask : pulse
endmodule : tcc_pulse_src
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench of the 8-bit capture timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    //==========================================================
    // signals
    localparam int FS = 2;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer_input_pin;
    logic        timer_irq;
    logic [31:0] q;
    logic        err;
    int          n_mismatch;
    int          checked;
    int          cyc = 0;
    int          t0;
    int          per [7] = '{4096, 1024, 128, FS * 16, FS * 4, 128, FS * 16};
    logic [1:0]  sel [7] = '{2'd0, 2'd1, 2'd2, 2'd0, 2'd1, 2'd2, 2'd0};
    logic        tp  [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic        slw [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

    tcc_timer #(.FS_DIV(FS)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_input_pin(timer_input_pin), .timer_irq(timer_irq));
    tcc_pulse_src src (.pclk(pclk), .pin(timer_input_pin));

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    //==========================================================
    // bus tasks; entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic wait_irq(input int lim);
        for (int i = 0; i < lim && timer_irq !== 1'b1; i++) @(posedge pclk);
    endtask : wait_irq

    function automatic logic [31:0] ctl(logic [1:0] m, logic [1:0] s, logic st, logic t,
                                        logic sl, logic sc);
        tcc_pkg::tcc_ctl_t c;
        c = '{slow: sl, soft_capture_request: sc, prescaler_tap_select: t, start: st,
              clk_sel: s, mode: m};
        return {24'h0, c};
    endfunction : ctl

    // event mode, running, soft capture then read of the capture register
    task automatic soft_cap;
        wr(tcc_pkg::ADDR_CTRL, ctl(2'd1, 2'd0, 1'b1, 1'b0, 1'b0, 1'b1));
        rd(tcc_pkg::ADDR_CAP_B);
    endtask : soft_cap

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // hang guard, well above the longest expected run
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end

    //==========================================================
    // tests
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        checked = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(tcc_pkg::ADDR_CTRL);
        `CHK(q, {24'h0, tcc_pkg::CTRL_RST})
        rd(tcc_pkg::ADDR_STATUS);
        `CHK(q, 32'h0)
        rd(8'h1c);
        `CHK(err, 1'b1)
        `CHK(q, 32'h0)
        $display("test reset done");

        for (int i = 0; i < 7; i++) begin
            wr(tcc_pkg::ADDR_CTRL, ctl(2'd0, sel[i], 1'b0, tp[i], slw[i], 1'b0));
            wr(tcc_pkg::ADDR_CMP_A, 32'h2);
            wr(tcc_pkg::ADDR_ENABLE, 32'h1 << tcc_pkg::ST_MATCH);
            wr(tcc_pkg::ADDR_CLEAR, 32'hf);
            wr(tcc_pkg::ADDR_CTRL, ctl(2'd0, sel[i], 1'b1, tp[i], slw[i], 1'b0));
            wait_irq(3 * per[i]);
            t0 = cyc;
            wr(tcc_pkg::ADDR_CLEAR, 32'h1 << tcc_pkg::ST_MATCH);
            `CHK(timer_irq, 1'b0)
            wait_irq(3 * per[i]);
            `CHK(cyc - t0, 2 * per[i])
        end
        // slow mode keeps only tap 0, so tap 1 must stay silent
        wr(tcc_pkg::ADDR_CTRL, ctl(2'd0, 2'd1, 1'b1, 1'b1, 1'b1, 1'b0));
        wr(tcc_pkg::ADDR_CLEAR, 32'hf);
        repeat (64) @(posedge pclk);
        `CHK(timer_irq, 1'b0)
        $display("test timer done");

        wr(tcc_pkg::ADDR_CTRL, ctl(2'd1, 2'd0, 1'b0, 1'b0, 1'b0, 1'b0));
        wr(tcc_pkg::ADDR_EXT_CTL, 32'h0);
        wr(tcc_pkg::ADDR_CMP_A, 32'h3);
        wr(tcc_pkg::ADDR_ENABLE, 32'h0);
        wr(tcc_pkg::ADDR_CLEAR, 32'hf);
        wr(tcc_pkg::ADDR_CTRL, ctl(2'd1, 2'd0, 1'b1, 1'b0, 1'b0, 1'b0));
        src.pulse(2);
        soft_cap();
        `CHK(q[7:0], 8'h02)
        rd(tcc_pkg::ADDR_CTRL);
        `CHK(q[6], 1'b0)
        src.pulse(1);
        rd(tcc_pkg::ADDR_STATUS);
        `CHK(q[tcc_pkg::ST_MATCH], 1'b1)
        `CHK(timer_irq, 1'b0)
        wr(tcc_pkg::ADDR_ENABLE, 32'h1 << tcc_pkg::ST_MATCH);
        `CHK(timer_irq, 1'b1)
        soft_cap();
        `CHK(q[7:0], 8'h00)
        wr(tcc_pkg::ADDR_CLEAR, 32'h1 << tcc_pkg::ST_MATCH);
        `CHK(timer_irq, 1'b0)
        src.pulse(3);
        `CHK(timer_irq, 1'b1)
        wr(tcc_pkg::ADDR_CTRL, ctl(2'd1, 2'd0, 1'b0, 1'b0, 1'b0, 1'b0));
        wr(tcc_pkg::ADDR_EXT_CTL, 32'h1 << tcc_pkg::EDGE_SEL_BIT);
        soft_cap();
        `CHK(q[7:0], 8'h00)
        src.level(1'b1, 8);
        soft_cap();
        `CHK(q[7:0], 8'h00)
        src.level(1'b0, 8);
        soft_cap();
        `CHK(q[7:0], 8'h01)
        // idle mode keeps the count while the pin toggles
        wr(tcc_pkg::ADDR_CTRL, ctl(2'd3, 2'd0, 1'b1, 1'b0, 1'b0, 1'b0));
        src.pulse(1);
        wr(tcc_pkg::ADDR_CTRL, ctl(2'd3, 2'd0, 1'b1, 1'b0, 1'b0, 1'b1));
        rd(tcc_pkg::ADDR_CAP_B);
        `CHK(q[7:0], 8'h01)
        $display("test event done");

        // tick of FS * 4 cycles, so 80 cycles make 10 counts
        wr(tcc_pkg::ADDR_CTRL, ctl(2'd2, 2'd1, 1'b0, 1'b1, 1'b0, 1'b0));
        wr(tcc_pkg::ADDR_EXT_CTL, 32'h0);
        wr(tcc_pkg::ADDR_ENABLE, (32'h1 << tcc_pkg::ST_CAP_A) | (32'h1 << tcc_pkg::ST_OVF));
        wr(tcc_pkg::ADDR_CLEAR, 32'hf);
        wr(tcc_pkg::ADDR_CTRL, ctl(2'd2, 2'd1, 1'b1, 1'b1, 1'b0, 1'b0));
        src.level(1'b1, 8);
        `CHK(timer_irq, 1'b1)
        rd(tcc_pkg::ADDR_CMP_A);
        wr(tcc_pkg::ADDR_CLEAR, 32'hf);
        repeat (66) @(posedge pclk);
        src.level(1'b0, 80);
        src.level(1'b1, 8);
        `CHK(timer_irq, 1'b1)
        src.level(1'b0, 8);
        src.level(1'b1, 8);
        rd(tcc_pkg::ADDR_CAP_B);
        `CHK(q[7:0] >= 8'h09 && q[7:0] <= 8'h0b, 1'b1)
        rd(tcc_pkg::ADDR_CMP_A);
        `CHK(q[7:0] >= 8'h13 && q[7:0] <= 8'h15, 1'b1)
        wr(tcc_pkg::ADDR_CLEAR, 32'hf);
        wait_irq(2200);
        rd(tcc_pkg::ADDR_STATUS);
        `CHK(q[tcc_pkg::ST_OVF], 1'b1)
        rd(tcc_pkg::ADDR_CMP_A);
        `CHK(q[7:0], 8'hff)
        $display("test capture done");
        // a second reset clears status but keeps the timer registers
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(timer_irq, 1'b0)
        rd(tcc_pkg::ADDR_CMP_A);
        `CHK(q[7:0], 8'hff)
        $display("test second reset done");
        report_and_stop();
    end
endmodule : testbench
`undef CHK
`default_nettype wire
